// ### verilog/fpe_pkg.sv
// fpe_pkg: constants, register map and state types of the flash program-once / erase-all sequencer
// assumes an AXI4-Lite master with 32-bit data on the register side
package fpe_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CMD_PARAM0 = 8'h00;
  localparam logic [7:0] OFS_PARAM_INDEX = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_CLKDIV = 8'h20;
  localparam logic [7:0] OFS_CONFIG = 8'h24;
  localparam logic [7:0] OFS_SECURITY = 8'h28;
  localparam logic [7:0] OFS_PROTECT = 8'h2C;
  localparam logic [7:0] OFS_MODE = 8'h30;
  localparam logic [7:0] OFS_FAULT = 8'h34;
  // command codes
  localparam logic [7:0] CMD_PROGRAM_ONCE = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
  localparam logic [2:0] IDX_PROGRAM_ONCE = 3'h5;
  localparam logic [2:0] IDX_ERASE_ALL = 3'h0;
  localparam int NUM_PHRASES = 8;
  localparam logic [15:0] MAX_PHRASE = 16'h0007;
  // status bit positions
  localparam int ST_CMD_COMPLETE_FLAG = 7;
  localparam int ST_ACCESS_ERROR_FLAG = 5;
  localparam int ST_PROTECTION_VIOLATION_FLAG = 4;
  localparam int ST_VERR = 1;
  localparam int ST_UERR = 0;
  localparam int CFG_ERASE_ALL_PENDING_POS = 0;
  // security field values
  localparam logic [1:0] SEC_UNSECURE = 2'h2;
  localparam logic [1:0] SEC_RESET = 2'h3;
  localparam logic [7:0] SEC_BYTE_RESET = 8'hFF;
  localparam logic [63:0] ERASED_WORD = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [7:0] CLKDIV_RESET = 8'h00;
  localparam logic [2:0] IDX_RESET = 3'h0;
  // operation step times
  localparam int STEP_NS = 200;
  localparam int CLK_NS = 10;
  localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE, S_BLANK, S_PROG, S_VERIFY, S_ERASE, S_EVERIFY, S_SECPROG, S_DONE
  } fpe_state_e;

  typedef struct packed {
    logic cmd_complete_flag;
    logic access_error_flag;
    logic protection_violation_flag;
    logic verr;
    logic uerr;
  } fpe_status_s;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } fpe_rd_s;
endpackage : fpe_pkg

// ### verilog/fpe_seq.sv
// fpe_seq: program-once and erase-all command sequencer with AXI4-Lite registers
// assumes MCLK domain for bus and array model; erase request pin is asynchronous
//
// What this block does
// R1 - software loads code 07, index, four words
// R2 - program-once only targets eight reserved phrases
// R3 - blank check, then program, then read back
// R4 - complete flag clear until operation ends
// R5 - refuse reprogramming a phrase, set access error
// R6 - access error unless index reads 101
// R7 - phrase index out of range gives error
// R8 - command not allowed in mode gives error
// R9 - array reads invalid while programming once
// R10 - verify errors set verify flag, never protection
// R11 - uncorrectable verify errors set second flag
// R12 - erase-all code 08 needs index 000
// R13 - erase all, verify, unsecure only on pass
// R14 - protected region sets protection violation flag
// R15 - software writes nothing during erase-all
// R16 - request pin starts erase-all without command
// R17 - divider unset at pin request: skip, error
// R18 - pin erase-all done resets clock divider
// R19 - flags cleared before pin request asserted; pin start does not check the error flags
// R20 - pin erase ignores protection, keeps it
// R21 - pin erase pass unsecures and programs byte
// R22 - pending bit set until pin erase done
// R23 - phrase is four 16-bit words, one unit
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module fpe_seq (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SOC_ERASE_ALL_REQ,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [7:0] ARRAY_RD_ADDR,
  output logic [63:0] ARRAY_RD_DATA,
  output logic ARRAY_RD_VALID,
  output logic ERASE_ALL_PENDING
);

  ////////////////////////////////////////////////////////////////////////////
  // all state of the sequencer, the bus slave and the array model
  typedef struct packed {
    logic [5:0][15:0] cmd_param_words;
    logic [2:0] param_index;
    fpe_pkg::fpe_status_s st;
    logic [7:0] clock_divider_reg;
    // set by a divider write, cleared by a pin erase-all; every launch needs it
    logic clkdiv_loaded;
    logic erase_all_pending;
    logic [1:0] security_state_field;
    logic [1:0] protect;
    logic [1:0] mode_deny;
    logic [1:0] fault_inject;
    logic [fpe_pkg::NUM_PHRASES-1:0] once_used;
    logic [fpe_pkg::NUM_PHRASES-1:0][63:0] once_data;
    logic [7:0] sec_byte;
    logic [63:0] main_word;
    fpe_pkg::fpe_state_e state;
    logic [7:0] step_cnt;
    logic pin_op;
    logic [2:0] phrase;
    logic req_s1;
    logic req_s2;
    logic req_d;
    logic [31:0] awaddr;
    logic aw_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_have;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    fpe_pkg::fpe_rd_s rd;
    logic [63:0] arr_data;
    logic arr_valid;
  } fpe_all_s;

  fpe_all_s q_r;
  fpe_all_s q_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge and decode helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic [7:0] word_ofs(input logic [31:0] a);
    return {a[7:2], 2'b00};
  endfunction : word_ofs

  // program-once steps, during which the array read port shows nothing
  function automatic logic once_busy(input fpe_pkg::fpe_state_e s);
    return s == fpe_pkg::S_BLANK || s == fpe_pkg::S_PROG || s == fpe_pkg::S_VERIFY;
  endfunction : once_busy

  logic [63:0] phrase_data;
  logic [7:0] wofs;
  logic [31:0] wval;
  logic [7:0] rofs;
  logic req_rise;
  logic [7:0] cmd_code;

  // four 16-bit words as one phrase
  assign phrase_data = {q_r.cmd_param_words[5], q_r.cmd_param_words[4],
                        q_r.cmd_param_words[3], q_r.cmd_param_words[2]}; // [R23]
  assign cmd_code = q_r.cmd_param_words[0][15:8]; // [R1]
  assign wofs = word_ofs(q_r.awaddr);
  assign rofs = word_ofs(S_AXI_ARADDR);
  // only the second sync flop feeds logic; the first is read by nothing else
  assign req_rise = q_r.req_s2 && !q_r.req_d;

  always_comb begin
    q_nxt = q_r;
    wval = 32'h0000_0000;
    q_nxt.req_s1 = SOC_ERASE_ALL_REQ;
    q_nxt.req_s2 = q_r.req_s1;
    q_nxt.req_d = q_r.req_s2;

    ////////////////////////////////////////////////////////////////////////////
    // bus write path
    if (S_AXI_AWVALID && !q_r.aw_have) begin
      q_nxt.awaddr = S_AXI_AWADDR;
      q_nxt.aw_have = 1'b1;
    end
    if (S_AXI_WVALID && !q_r.w_have) begin
      q_nxt.wdata = S_AXI_WDATA;
      q_nxt.wstrb = S_AXI_WSTRB;
      q_nxt.w_have = 1'b1;
    end
    if (q_r.aw_have && q_r.w_have && !q_r.bvalid) begin
      q_nxt.aw_have = 1'b0;
      q_nxt.w_have = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = fpe_pkg::RESP_OKAY;
      // writes while busy are dropped so a running operation cannot be disturbed
      if (!q_r.st.cmd_complete_flag) begin
        q_nxt.bresp = fpe_pkg::RESP_SLVERR; // [R15]
      end else if (wofs < fpe_pkg::OFS_PARAM_INDEX) begin
        wval = merge({16'h0000, q_r.cmd_param_words[wofs[4:2]]}, q_r.wdata, q_r.wstrb);
        q_nxt.cmd_param_words[wofs[4:2]] = wval[15:0];
        q_nxt.param_index = wofs[4:2];
      end else begin
        case (wofs)
          fpe_pkg::OFS_PARAM_INDEX: begin
            wval = merge({29'h0, q_r.param_index}, q_r.wdata, q_r.wstrb);
            q_nxt.param_index = wval[2:0];
          end
          fpe_pkg::OFS_STATUS: begin
            // write one to clear access error and protection violation flags, write one to cmd_complete_flag launches
            if (q_r.wdata[fpe_pkg::ST_ACCESS_ERROR_FLAG] && q_r.wstrb[0]) q_nxt.st.access_error_flag = 1'b0;
            if (q_r.wdata[fpe_pkg::ST_PROTECTION_VIOLATION_FLAG] && q_r.wstrb[0]) q_nxt.st.protection_violation_flag = 1'b0;
            if (q_r.wdata[fpe_pkg::ST_CMD_COMPLETE_FLAG] && q_r.wstrb[0] && !q_r.st.access_error_flag &&
                !q_r.st.protection_violation_flag) begin
              q_nxt.st.cmd_complete_flag = 1'b0;
              q_nxt.st.verr = 1'b0;
              q_nxt.st.uerr = 1'b0;
              q_nxt.pin_op = 1'b0;
              q_nxt.step_cnt = 8'h00;
              q_nxt.phrase = q_r.cmd_param_words[1][2:0];
              if (!q_r.clkdiv_loaded) begin
                q_nxt.st.access_error_flag = 1'b1;
                q_nxt.state = fpe_pkg::S_DONE;
              end else if (cmd_code == fpe_pkg::CMD_PROGRAM_ONCE) begin
                if (q_r.param_index != fpe_pkg::IDX_PROGRAM_ONCE || // [R6]
                    q_r.mode_deny[0] || // [R8]
                    q_r.cmd_param_words[1] > fpe_pkg::MAX_PHRASE) begin // [R7] [R2]
                  q_nxt.st.access_error_flag = 1'b1;
                  q_nxt.state = fpe_pkg::S_DONE;
                end else begin
                  q_nxt.state = fpe_pkg::S_BLANK; // [R3]
                end
              end else if (cmd_code == fpe_pkg::CMD_ERASE_ALL) begin
                if (q_r.param_index != fpe_pkg::IDX_ERASE_ALL || q_r.mode_deny[1]) begin
                  q_nxt.st.access_error_flag = 1'b1; // [R12] [R8]
                  q_nxt.state = fpe_pkg::S_DONE;
                end else if (q_r.protect != 2'b00) begin
                  q_nxt.st.protection_violation_flag = 1'b1; // [R14]
                  q_nxt.state = fpe_pkg::S_DONE;
                end else begin
                  q_nxt.state = fpe_pkg::S_ERASE; // [R13]
                end
              end else begin
                q_nxt.st.access_error_flag = 1'b1;
                q_nxt.state = fpe_pkg::S_DONE;
              end
            end
          end
          fpe_pkg::OFS_CLKDIV: begin
            wval = merge({24'h0, q_r.clock_divider_reg}, q_r.wdata, q_r.wstrb);
            q_nxt.clock_divider_reg = wval[7:0];
            q_nxt.clkdiv_loaded = 1'b1;
          end
          fpe_pkg::OFS_PROTECT: q_nxt.protect = q_r.wdata[1:0];
          fpe_pkg::OFS_MODE: q_nxt.mode_deny = q_r.wdata[1:0];
          fpe_pkg::OFS_FAULT: q_nxt.fault_inject = q_r.wdata[1:0];
          default: q_nxt.bresp = fpe_pkg::RESP_SLVERR;
        endcase
      end
    end
    if (q_r.bvalid && S_AXI_BREADY) begin
      q_nxt.bvalid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus read path
    if (S_AXI_ARVALID && !q_r.rvalid) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rd.resp = fpe_pkg::RESP_OKAY;
      q_nxt.rd.data = 32'h0000_0000;
      if (rofs < fpe_pkg::OFS_PARAM_INDEX) begin
        q_nxt.rd.data = {16'h0000, q_r.cmd_param_words[rofs[4:2]]};
      end else begin
        case (rofs)
          fpe_pkg::OFS_PARAM_INDEX: q_nxt.rd.data = {29'h0, q_r.param_index};
          fpe_pkg::OFS_STATUS: q_nxt.rd.data = {24'h0, q_r.st.cmd_complete_flag, 1'b0, q_r.st.access_error_flag,
                                                q_r.st.protection_violation_flag, 2'b00, q_r.st.verr,
                                                q_r.st.uerr};
          fpe_pkg::OFS_CLKDIV: q_nxt.rd.data = {23'h0, q_r.clkdiv_loaded,
                                                q_r.clock_divider_reg};
          fpe_pkg::OFS_CONFIG: q_nxt.rd.data = {31'h0, q_r.erase_all_pending};
          fpe_pkg::OFS_SECURITY: q_nxt.rd.data = {22'h0, q_r.sec_byte,
                                                  q_r.security_state_field};
          fpe_pkg::OFS_PROTECT: q_nxt.rd.data = {30'h0, q_r.protect};
          fpe_pkg::OFS_MODE: q_nxt.rd.data = {30'h0, q_r.mode_deny};
          fpe_pkg::OFS_FAULT: q_nxt.rd.data = {30'h0, q_r.fault_inject};
          default: q_nxt.rd.resp = fpe_pkg::RESP_SLVERR;
        endcase
      end
    end else if (q_r.rvalid && S_AXI_RREADY) begin
      q_nxt.rvalid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin request, only from idle
    // a rise while a command runs is lost, so system logic must raise the pin again;
    // it sits after the bus path so its flag sets win over a same-cycle clear
    if (req_rise && q_r.state == fpe_pkg::S_IDLE && q_r.st.cmd_complete_flag) begin
      q_nxt.st.cmd_complete_flag = 1'b0;
      q_nxt.st.verr = 1'b0;
      q_nxt.st.uerr = 1'b0;
      q_nxt.step_cnt = 8'h00;
      q_nxt.pin_op = 1'b1; // [R16]
      if (!q_r.clkdiv_loaded) begin
        q_nxt.st.access_error_flag = 1'b1; // [R17]
        q_nxt.state = fpe_pkg::S_DONE;
      end else begin
        q_nxt.erase_all_pending = 1'b1; // [R22]
        q_nxt.state = fpe_pkg::S_ERASE; // [R20]
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer; each array step takes a fixed time
    if (q_r.state != fpe_pkg::S_IDLE && q_r.state != fpe_pkg::S_DONE) begin
      q_nxt.step_cnt = q_r.step_cnt + 8'h01;
    end
    if (q_r.step_cnt == 8'(fpe_pkg::STEP_CYC - 1)) begin
      q_nxt.step_cnt = 8'h00;
      case (q_r.state)
        fpe_pkg::S_BLANK: begin
          if (q_r.once_used[q_r.phrase]) begin
            q_nxt.st.access_error_flag = 1'b1; // [R5]
            q_nxt.state = fpe_pkg::S_DONE;
          end else begin
            q_nxt.state = fpe_pkg::S_PROG;
          end
        end
        fpe_pkg::S_PROG: begin
          q_nxt.once_data[q_r.phrase] = phrase_data; // [R23]
          q_nxt.once_used[q_r.phrase] = 1'b1;
          q_nxt.state = fpe_pkg::S_VERIFY;
        end
        fpe_pkg::S_VERIFY: begin
          // read back; fault_inject models a marginal cell
          if (q_r.once_data[q_r.phrase] != phrase_data || q_r.fault_inject[0]) begin
            q_nxt.st.verr = 1'b1; // [R10]
            q_nxt.st.uerr = q_r.fault_inject[1]; // [R11]
          end
          q_nxt.state = fpe_pkg::S_DONE;
        end
        fpe_pkg::S_ERASE: begin
          q_nxt.main_word = fpe_pkg::ERASED_WORD;
          q_nxt.state = fpe_pkg::S_EVERIFY;
        end
        fpe_pkg::S_EVERIFY: begin
          // read the erased word back as well as the fault model
          if (q_r.main_word != fpe_pkg::ERASED_WORD || q_r.fault_inject[0]) begin
            q_nxt.st.verr = 1'b1;
            q_nxt.st.uerr = q_r.fault_inject[1];
            q_nxt.state = fpe_pkg::S_DONE;
          end else begin
            q_nxt.security_state_field = fpe_pkg::SEC_UNSECURE; // [R13] [R21]
            q_nxt.state = q_r.pin_op ? fpe_pkg::S_SECPROG : fpe_pkg::S_DONE;
          end
        end
        fpe_pkg::S_SECPROG: begin
          q_nxt.sec_byte = {6'h3F, fpe_pkg::SEC_UNSECURE}; // [R21]
          q_nxt.state = fpe_pkg::S_DONE;
        end
        default: ;
      endcase
    end
    if (q_r.state == fpe_pkg::S_DONE) begin
      q_nxt.st.cmd_complete_flag = 1'b1; // [R4]
      q_nxt.state = fpe_pkg::S_IDLE;
      if (q_r.pin_op) begin
        q_nxt.erase_all_pending = 1'b0; // [R22]
        q_nxt.clock_divider_reg = fpe_pkg::CLKDIV_RESET; // [R18]
        q_nxt.clkdiv_loaded = 1'b0;
      end
    end

    // array read port: invalid while program-once runs
    q_nxt.arr_valid = !once_busy(q_r.state); // [R9]
    q_nxt.arr_data = q_nxt.arr_valid ? (ARRAY_RD_ADDR[7] ? q_r.once_data[ARRAY_RD_ADDR[2:0]]
                                                          : q_r.main_word)
                                     : 64'h0000_0000_0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      // limitation: the once field lives in flops here, so a reset forgets used phrases
      q_r <= '0;
      q_r.st.cmd_complete_flag <= 1'b1;
      q_r.state <= fpe_pkg::S_IDLE;
      q_r.security_state_field <= fpe_pkg::SEC_RESET;
      q_r.sec_byte <= fpe_pkg::SEC_BYTE_RESET;
      q_r.main_word <= fpe_pkg::ERASED_WORD;
      q_r.param_index <= fpe_pkg::IDX_RESET;
      q_r.clock_divider_reg <= fpe_pkg::CLKDIV_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readies come straight from the held flags, so each channel holds one item at a time
  assign S_AXI_AWREADY = !q_r.aw_have;
  assign S_AXI_WREADY = !q_r.w_have;
  assign S_AXI_BVALID = q_r.bvalid;
  assign S_AXI_BRESP = q_r.bresp;
  assign S_AXI_ARREADY = !q_r.rvalid;
  assign S_AXI_RVALID = q_r.rvalid;
  assign S_AXI_RDATA = q_r.rd.data;
  assign S_AXI_RRESP = q_r.rd.resp;
  assign ARRAY_RD_DATA = q_r.arr_data;
  assign ARRAY_RD_VALID = q_r.arr_valid;
  assign ERASE_ALL_PENDING = q_r.erase_all_pending;
endmodule : fpe_seq

// ### verification/fpe_seq_asserts.sv
// fpe_seq_asserts: port-level timing checks of the sequencer
// assumes a bind onto fpe_seq, one MCLK domain, async active-low reset
`timescale 1ns/10ps
module fpe_seq_asserts (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SOC_ERASE_ALL_REQ,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [63:0] ARRAY_RD_DATA,
  input wire logic ARRAY_RD_VALID,
  input wire logic ERASE_ALL_PENDING
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  b_hold_a: assert property (S_AXI_BVALID |=> ($past(S_AXI_BREADY) ? !S_AXI_BVALID
    : S_AXI_BVALID && $stable(S_AXI_BRESP)))
    else $error("write response not held or not released");
  r_hold_a: assert property (S_AXI_RVALID |=> ($past(S_AXI_RREADY) ? !S_AXI_RVALID
    : S_AXI_RVALID && $stable(S_AXI_RDATA)))
    else $error("read data not held or not released");
  r_latency_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  b_latency_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##2 S_AXI_BVALID) else $error("write answer late");
  ar_gate_a: assert property (S_AXI_ARREADY != S_AXI_RVALID)
    else $error("read address ready while answer pending");
  array_blank_a: assert property (!ARRAY_RD_VALID |-> ARRAY_RD_DATA == 64'h0)
    else $error("array data shown while invalid");
  pin_start_a: assert property ($rose(ERASE_ALL_PENDING) |-> $past(SOC_ERASE_ALL_REQ, 2))
    else $error("pending rose without pin request");
  pend_len_a: assert property ($rose(ERASE_ALL_PENDING) |=> ERASE_ALL_PENDING [*8])
    else $error("pending cleared too soon");
endmodule : fpe_seq_asserts

// ### verification/fpe_seq_tb_top.sv
// fpe_seq_tb_top: self-checking bench of the program-once / erase-all sequencer
// assumes fpe_seq with an AXI4-Lite slave; bready and rready are held high
`timescale 1ns/10ps
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module fpe_seq_tb_top;
  typedef struct packed {logic [1:0] r; logic [31:0] d; logic [31:0] m;} fpe_exp_s;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic pin = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, last = 32'h0, seed = 32'h25;
  logic [7:0] raddr = 8'h0;
  logic [15:0] w [4];
  wire awready, wready, bvalid, arready, rvalid, pend, avalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [63:0] adata;
  wire [2:0] rdy = {bvalid, rvalid, arready};
  int fails = 0, check_count = 0;
  fpe_exp_s rq [$];
  logic [1:0] bq [$];
  always #5 MCLK = ~MCLK;
  fpe_seq i_dut (
    .MCLK(MCLK), .RST_N(RST_N), .SOC_ERASE_ALL_REQ(pin),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
    .ARRAY_RD_ADDR(raddr), .ARRAY_RD_DATA(adata), .ARRAY_RD_VALID(avalid),
    .ERASE_ALL_PENDING(pend)
  );
  ////////////////////////////////////////////////////////////////////////////
  // a result is taken at the negedge before the edge that completes it
  always @(negedge MCLK) begin : watch
    fpe_exp_s e;
    if (bvalid) `CHK(bresp, bq.pop_front(), "write response")
    if (rvalid) begin
      e = rq.pop_front();
      `CHK(rresp, e.r, "read response")
      if (e.m != 32'h0) `CHK(rdata & e.m, e.d & e.m, "read data")
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic wt(input int k);
    logic g;
    do begin
      @(negedge MCLK);
      g = rdy[k];
      last = rdata;
      @(posedge MCLK);
    end while (!g);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, na, nw;
    bq.push_back(r);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(negedge MCLK);
      na = awready && !ta;
      nw = wready && !tw;
      @(posedge MCLK);
      if (na) awvalid <= 1'b0;
      if (nw) wvalid <= 1'b0;
      ta = ta | na;
      tw = tw | nw;
    end
    wt(2);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    rq.push_back({(a > fpe_pkg::OFS_FAULT) ? fpe_pkg::RESP_SLVERR : fpe_pkg::RESP_OKAY, d, m});
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    wt(0);
    arvalid <= 1'b0;
    wt(1);
  endtask : rd
  task automatic poll();
    last = 32'h0;
    for (int i = 0; i < 60 && !last[7]; i++) rd(8'h1C, 32'h0, 32'h0);
    `CHK(last[7], 1'b1, "command never completed")
  endtask : poll
  task automatic wp(input logic v, input int n);
    logic g;
    g = 1'b0;
    for (int i = 0; i < n && !g; i++) begin
      @(negedge MCLK);
      g = (pend === v);
      @(posedge MCLK);
    end
    `CHK(g, 1'b1, "pending level")
  endtask : wp
  task automatic arr(input logic [2:0] p);
    raddr <= {5'h10, p};
    @(posedge MCLK);
    @(negedge MCLK);
    `CHK(adata, {w[3], w[2], w[1], w[0]}, "phrase data")
    `CHK(avalid, 1'b1, "array not readable while idle")
    @(posedge MCLK);
  endtask : arr
  // loads n parameter words, launches, checks the busy window when b, then final flags
  task automatic cmd(input logic [7:0] c, input logic [15:0] ix, input int n,
                     input logic [7:0] st, input logic b);
    for (int i = 0; i < n; i++) begin
      wr(8'(4 * i), i == 0 ? {16'h0, c, 8'h0} : i == 1 ? {16'h0, ix} : {16'h0, w[i - 2]},
         2'h0);
    end
    wr(8'h1C, 32'h80, 2'h0);
    if (b) begin
      rd(8'h1C, 32'h0, 32'h80);
      wr(8'h18, 32'h0, 2'h2);
      if (c == fpe_pkg::CMD_PROGRAM_ONCE) `CHK(avalid, 1'b0, "array readable")
    end
    poll();
    rd(8'h1C, {24'h0, st}, 32'hB3);
    wr(8'h1C, 32'h30, 2'h0);
  endtask : cmd
  task automatic give_verdict();
    $display("TB: checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin : dog
    #200_000;
    fails++;
    give_verdict();
  end
  initial begin : main
    repeat (8) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    rd(8'h1C, 32'h80, 32'hB3);
    rd(8'h28, 32'h3FF, 32'h3FF);
    wr(8'h3C, 32'h0, 2'h2); // unmapped place
    rd(8'h3C, 32'h0, 32'hFFFF_FFFF);
    cmd(8'h08, 16'h0, 1, 8'hA0, 1'b0);
    wr(8'h20, 32'h13, 2'h0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      w[i] = seed[15:0];
    end
    cmd(8'h07, 16'h7, 5, 8'hA0, 1'b0);
    cmd(8'h07, 16'h8, 6, 8'hA0, 1'b0);
    for (int m = 1; m < 3; m++) begin
      wr(8'h30, 32'(m), 2'h0);
      cmd(m == 1 ? 8'h07 : 8'h08, 16'h7, m == 1 ? 6 : 1, 8'hA0, 1'b0);
    end
    wr(8'h30, 32'h0, 2'h0);
    cmd(8'h07, 16'h7, 6, 8'h80, 1'b1);
    arr(3'h7);
    cmd(8'h07, 16'h7, 6, 8'hA0, 1'b0);
    wr(8'h2C, 32'h1, 2'h0);
    cmd(8'h08, 16'h0, 1, 8'h90, 1'b0);
    wr(8'h2C, 32'h0, 2'h0);
    cmd(8'h08, 16'h0, 2, 8'hA0, 1'b0);
    cmd(8'h08, 16'h0, 1, 8'h80, 1'b1);
    rd(8'h28, 32'h2, 32'h3);
    arr(3'h7);
    wr(8'h34, 32'h3, 2'h0);
    cmd(8'h07, 16'h0, 6, 8'h83, 1'b1);
    RST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    rd(8'h28, 32'h3FF, 32'h3FF);
    pin <= 1'b1;
    repeat (10) @(posedge MCLK);
    pin <= 1'b0;
    wp(1'b0, 1);
    poll();
    rd(8'h1C, 32'hA0, 32'hB3);
    wr(8'h1C, 32'h30, 2'h0);
    wr(8'h20, 32'h13, 2'h0);
    wr(8'h2C, 32'h3, 2'h0);
    pin <= 1'b1;
    wp(1'b1, 20);
    pin <= 1'b0;
    wp(1'b0, 300);
    rd(8'h1C, 32'h80, 32'hB3);
    rd(8'h20, 32'h0, 32'h1FF);
    rd(8'h2C, 32'h3, 32'h3);
    rd(8'h28, 32'h3FA, 32'h3FF);
    cmd(8'h08, 16'h0, 1, 8'hA0, 1'b0);
    give_verdict();
  end
endmodule : fpe_seq_tb_top
bind fpe_seq fpe_seq_asserts i_chk (
  .MCLK(MCLK), .RST_N(RST_N), .SOC_ERASE_ALL_REQ(SOC_ERASE_ALL_REQ),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .ARRAY_RD_DATA(ARRAY_RD_DATA),
  .ARRAY_RD_VALID(ARRAY_RD_VALID), .ERASE_ALL_PENDING(ERASE_ALL_PENDING)
);
